// *** sacr_core.v ***
/*
 * conversion sequencer and serial readout of a 12-bit sampling converter.
 * holds the pin synchronisers and edge detection, the conversion timer,
 * the internal bit clock generator, the host bit clock shifter, the
 * hold-off timer and the pin enables.
 * assumes: the analog decision logic delivers a 12-bit two's complement
 * word on sample_code_in when asked; pins arrive asynchronous and pass two flops.
 * assumes one core clock; every internal timing figure is a count of its cycles.
 */
`timescale 1ns/1ns
`include "sacr_defs.vh"

module sacr_core #(
    parameter BUSY_CYC = `SACR_BUSY_CYC
)
(
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire convert_start_n_in,
    input wire device_select_n_in,
    input wire clock_source_select_in,
    input wire serial_bit_clock_in,
    input wire [11:0] sample_code_in,
    output wire sample_hold_out,
    output wire busy_n_out,
    output wire busy_n_oe_n_out,
    output wire data_out,
    output wire data_oe_n_out,
    output wire serial_bit_clock_out,
    output wire serial_bit_clock_oe_n_out
);

// ****************************************************************
// input synchronisers
// ****************************************************************
reg [1:0] convert_start_n_sync_q;
reg [1:0] sel_sync_q;
reg [1:0] src_sync_q;
reg [1:0] sclk_sync_q;
reg convert_start_n_prev_q;
reg sclk_prev_q;

always @(posedge ref_clk_in or posedge sys_rst_in)
begin
    if (sys_rst_in)
    begin
        convert_start_n_sync_q <= 2'h3;
        sel_sync_q <= 2'h3;
        src_sync_q <= 2'h0;
        sclk_sync_q <= 2'h0;
        // reset levels match the idle pins, so no false edge follows reset
        convert_start_n_prev_q <= 1'b1;
        sclk_prev_q <= 1'b0;
    end
    else
    begin
        convert_start_n_sync_q <= {convert_start_n_sync_q[0], convert_start_n_in};
        sel_sync_q <= {sel_sync_q[0], device_select_n_in};
        src_sync_q <= {src_sync_q[0], clock_source_select_in};
        sclk_sync_q <= {sclk_sync_q[0], serial_bit_clock_in};
        convert_start_n_prev_q <= convert_start_n_sync_q[1];
        sclk_prev_q <= sclk_sync_q[1];
    end
end

// ****************************************************************
// edge detection
// ****************************************************************

wire convert_start_n_fall = convert_start_n_prev_q & ~convert_start_n_sync_q[1];
wire sel_n = sel_sync_q[1];
wire ext_mode = src_sync_q[1];
wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;

// ****************************************************************
// conversion sequencer
// ****************************************************************
localparam [1:0] ST_IDLE = `SACR_ST_IDLE;
localparam [1:0] ST_CONVERT_START_N = `SACR_ST_CONVERT_START_N;
localparam [15:0] FIRST_CYC = `SACR_FIRST_CYC;
localparam [15:0] HIGH_CYC = `SACR_HIGH_CYC;
localparam [15:0] LOW_CYC = `SACR_LOW_CYC;
localparam [15:0] TAIL_CYC = `SACR_TAIL_CYC;
localparam [15:0] XFER_CYC = `SACR_XFER_CYC;
localparam [15:0] HOLDOFF_CYC = `SACR_HOLDOFF_CYC;
localparam [15:0] BUSY_LEN = BUSY_CYC;
localparam [3:0] WORD_BITS = `SACR_WORD_BITS;
localparam [3:0] OVER_BIT = `SACR_OVER_BIT;

// ****************************************************************
// state and counters
// ****************************************************************

reg [1:0] state_q;
reg [15:0] convert_start_n_cnt_q;
reg [11:0] work_q;
reg [11:0] shift_q;
reg [3:0] bit_cnt_q;
reg data_q;
reg ibclk_q;
reg [15:0] quiet_cnt_q;
reg [15:0] phase_cnt_q;

// internal mode: the result goes out during the next conversion, so the
// whole frame is timed from the conversion counter alone
function [15:0] bit_start;
    input [3:0] idx;
    begin
        bit_start = FIRST_CYC + ({12'h000, idx} * (HIGH_CYC + LOW_CYC));
    end
endfunction

// bit put on the pin by a host clock rise; zero once the word is spent
function next_bit;
    input [3:0] cnt;
    input msb;
    begin
        next_bit = (cnt < WORD_BITS) ? msb : 1'b0;
    end
endfunction

// ****************************************************************
// internal bit clock timing
// ****************************************************************
// every edge is a compare against the conversion counter, so the frame cannot drift from busy
// data is cleared where the next bit would load, well after the last fall
wire [15:0] frame_end = bit_start(WORD_BITS) - 16'h0001;
wire bit_active = (bit_cnt_q < WORD_BITS);
wire bit_load = bit_active && (convert_start_n_cnt_q == bit_start(bit_cnt_q) - 16'h0001);
wire bit_rise = bit_active && (convert_start_n_cnt_q == bit_start(bit_cnt_q));
wire bit_fall = bit_active && (convert_start_n_cnt_q == bit_start(bit_cnt_q) + HIGH_CYC);
wire convert_start_n_done = (state_q == ST_CONVERT_START_N) && (convert_start_n_cnt_q == BUSY_LEN - 16'h0001);

// ****************************************************************
// hold-off timer
// ****************************************************************
// host clock low and quiet long enough before busy rises, or deselected
wire holdoff_ok = (quiet_cnt_q >= HOLDOFF_CYC);

// keep the hold-off timer sampled so that sel_n high also counts as quiet
always @(posedge ref_clk_in or posedge sys_rst_in)
begin
    if (sys_rst_in)
        quiet_cnt_q <= 16'h0000;
    else if (sclk_sync_q[1] && !sel_n)
        quiet_cnt_q <= 16'h0000;
    else if (quiet_cnt_q != 16'hffff)
        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
end

// ****************************************************************
// conversion timer and shifter
// ****************************************************************

always @(posedge ref_clk_in or posedge sys_rst_in)
begin
    if (sys_rst_in)
    begin
        state_q <= ST_IDLE;
        convert_start_n_cnt_q <= 16'h0000;
        work_q <= 12'h000;
        shift_q <= 12'h000;
        bit_cnt_q <= 4'h0;
        data_q <= 1'b0;
        ibclk_q <= 1'b0;
        phase_cnt_q <= 16'h0000;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
            begin
                ibclk_q <= 1'b0;
                if (!ext_mode)
                    data_q <= 1'b0;
                if (convert_start_n_fall)
                begin
                    state_q <= ST_CONVERT_START_N;
                    convert_start_n_cnt_q <= 16'h0000;
                    phase_cnt_q <= 16'h0000;
                    bit_cnt_q <= 4'h0;
                end
                else if (ext_mode && sclk_rise && !sel_n)
                begin
                    // low after twelve
                    // host rises are only taken while selected, as the shift is gated by sel_n
                    data_q <= next_bit(bit_cnt_q, shift_q[11]);
                    shift_q <= {shift_q[10:0], 1'b0};
                    if (bit_cnt_q < OVER_BIT)
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end
            ST_CONVERT_START_N:
            begin
                convert_start_n_cnt_q <= convert_start_n_cnt_q + 16'h0001;
                if (!ext_mode)
                begin
                    if (bit_load)
                    begin
                        data_q <= shift_q[11];
                        shift_q <= {shift_q[10:0], 1'b0};
                        phase_cnt_q <= 16'h0000;
                    end
                    if (bit_rise)
                        ibclk_q <= 1'b1;
                    if (bit_fall)
                    begin
                        ibclk_q <= 1'b0;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    // data stays through the low phase, cleared when the frame ends
                    if (convert_start_n_cnt_q == frame_end)
                        data_q <= 1'b0;
                end
                else if (sclk_rise && !sel_n)
                begin
                    data_q <= next_bit(bit_cnt_q, shift_q[11]);
                    shift_q <= {shift_q[10:0], 1'b0};
                    if (bit_cnt_q < OVER_BIT)
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                if (convert_start_n_cnt_q == BUSY_LEN - XFER_CYC)
                    work_q <= sample_code_in;
                if (convert_start_n_done)
                begin
                    if (!ext_mode || holdoff_ok)
                    begin
                        shift_q <= work_q;
                        bit_cnt_q <= 4'h0;
                    end
                    state_q <= ST_IDLE;
                    ibclk_q <= 1'b0;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

// ****************************************************************
// pin drivers
// ****************************************************************
// busy tracks conversion
assign busy_n_out = (state_q != ST_CONVERT_START_N);
assign sample_hold_out = (state_q == ST_CONVERT_START_N);

// ****************************************************************
// pin enables
// ****************************************************************
// select gates outputs
assign busy_n_oe_n_out = sel_n;
assign data_out = data_q;
assign data_oe_n_out = sel_n;
assign serial_bit_clock_out = ibclk_q;
// a frame sent while deselected is lost; the host sees nothing of it
assign serial_bit_clock_oe_n_out = sel_n | ext_mode;

endmodule // sacr_core

// *** sacr_defs.vh ***
/*
 * shared constants of the converter sequencer and serial readout:
 * timing figures in their own units and cycle counts derived from them.
 * assumes a 10 ns core clock; change SACR_CLK_NS here if the core clock differs.
 */
`ifndef SACR_DEFS_VH
`define SACR_DEFS_VH

`define SACR_CLK_NS 10
// ****************************************************************
// timing figures
// ****************************************************************
`define SACR_BUSY_LOW_NS 15000
`define SACR_FIRST_RISE_NS 1400
`define SACR_BIT_HIGH_NS 350
`define SACR_BIT_LOW_NS 760
`define SACR_TAIL_NS 800
`define SACR_XFER_BEFORE_NS 1100
`define SACR_HOLDOFF_NS 2000
// ****************************************************************
// derived cycle counts
// ****************************************************************
`define SACR_BUSY_CYC (`SACR_BUSY_LOW_NS / `SACR_CLK_NS)
`define SACR_FIRST_CYC (`SACR_FIRST_RISE_NS / `SACR_CLK_NS)
`define SACR_HIGH_CYC ((`SACR_BIT_HIGH_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS)
`define SACR_LOW_CYC ((`SACR_BIT_LOW_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS)
`define SACR_TAIL_CYC (`SACR_TAIL_NS / `SACR_CLK_NS)
`define SACR_XFER_CYC (`SACR_XFER_BEFORE_NS / `SACR_CLK_NS)
`define SACR_HOLDOFF_CYC ((`SACR_HOLDOFF_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS)
// ****************************************************************
// states and codes
// ****************************************************************
`define SACR_ST_IDLE 2'h0
`define SACR_ST_CONVERT_START_N 2'h1
`define SACR_WORD_BITS 12
`define SACR_OVER_BIT 13

`endif

// *** sacr_core_monitor.sv ***
/* pin checker of the converter sequencer;
   assumes it is bound to sacr_core and sees only its ports */
`timescale 1ns/1ns
module sacr_mon_core #(
    parameter BUSY_CYC = 1500
)
(
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire convert_start_n_in,
    input wire device_select_n_in,
    input wire clock_source_select_in,
    input wire sample_hold_out,
    input wire busy_n_out,
    input wire busy_n_oe_n_out,
    input wire data_out,
    input wire data_oe_n_out,
    input wire serial_bit_clock_out
);
    reg [11:0] low_q;
    wire [11:0] low_d;
    // counts busy-low cycles so the length can be judged at the rise
    assign low_d = busy_n_out ? 12'h000 : low_q + 12'h001;
    always @(posedge ref_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
            low_q <= 12'h000;
        else
            low_q <= low_d;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_busy_fall_fast: assert property (
        $fell(convert_start_n_in) && busy_n_out |-> ##[1:12] !busy_n_out)
        else $error("busy fell late");
    a_busy_len_ok: assert property (
        $rose(busy_n_out) |-> low_q >= BUSY_CYC - 1 && low_q <= BUSY_CYC)
        else $error("busy low length wrong");
    a_idle_clk_low: assert property (
        busy_n_out && !clock_source_select_in |-> !serial_bit_clock_out)
        else $error("bit clock outside frame");
    a_bit_stable: assert property (
        serial_bit_clock_out || $fell(serial_bit_clock_out) |-> $stable(data_out))
        else $error("data moved near bit clock edge");
    a_clk_in_frame: assert property (
        serial_bit_clock_out |-> !busy_n_out)
        else $error("bit clock while idle");
    a_oe_on_fast: assert property (
        $fell(device_select_n_in) |-> ##[1:8] !busy_n_oe_n_out && !data_oe_n_out)
        else $error("outputs enabled late");
    a_oe_off_fast: assert property (
        $rose(device_select_n_in) |-> ##[1:8] busy_n_oe_n_out && data_oe_n_out)
        else $error("outputs released late");
    a_hold_tracks: assert property (
        sample_hold_out == !busy_n_out)
        else $error("hold and busy disagree");
endmodule // sacr_mon_core

bind sacr_core sacr_mon_core #(.BUSY_CYC(BUSY_CYC)) sacr_mon_core_inst (.ref_clk_in,
    .sys_rst_in, .convert_start_n_in, .device_select_n_in, .clock_source_select_in,
    .sample_hold_out, .busy_n_out, .busy_n_oe_n_out, .data_out, .data_oe_n_out,
    .serial_bit_clock_out);

// *** sacr_host_model.sv ***
/* host model: bursts of the host bit clock at 125 ns, data taken on falls;
   assumes the bench raises run_in once per burst, after the conversion */
`timescale 1ns/1ns
module sacr_host_model
(
    input wire run_in,
    input wire [3:0] nbits_in,
    input wire data_in,
    output reg serial_bit_clock_out,
    output reg [12:0] word_out
);
    initial serial_bit_clock_out = 1'b0;
    always @(posedge run_in)
    begin
        word_out = 13'h0000;
        repeat (nbits_in)
        begin
            #62 serial_bit_clock_out = 1'b1;
            #63 serial_bit_clock_out = 1'b0;
            word_out = {word_out[11:0], data_in};
        end
    end
endmodule // sacr_host_model

// *** sacr_core_tb_top.sv ***
/* self-checking bench of sacr_core with the host model;
   assumes a 100 MHz core clock */
`timescale 1ns/1ns
module sacr_core_tb_top;
    localparam BUSY_CYC = 1500;
    localparam [59:0] CODES = 60'h7ff_000_fff_800_5a3;
    reg ref_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg convert_start_n_n = 1'b1;
    reg sel_n = 1'b0;
    reg src = 1'b0;
    reg run = 1'b0;
    reg [11:0] code = 12'h000;
    reg [11:0] word;
    reg [15:0] nb;
    reg [15:0] len;
    wire busy_n, busy_oe_n, dout, dout_oe_n, sclk, hclk, hold, dpin, sclk_oe_n;
    wire [12:0] hword;
    integer error_cnt = 0;
    integer n_checks = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    // a released pin never shows a stale level
    assign dpin = dout_oe_n ? ~dout : dout;
    sacr_core #(.BUSY_CYC(BUSY_CYC)) sacr_core_inst (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .convert_start_n_in(convert_start_n_n), .device_select_n_in(sel_n),
        .clock_source_select_in(src), .serial_bit_clock_in(hclk), .sample_code_in(code),
        .sample_hold_out(hold), .busy_n_out(busy_n), .busy_n_oe_n_out(busy_oe_n),
        .data_out(dout), .data_oe_n_out(dout_oe_n), .serial_bit_clock_out(sclk),
        .serial_bit_clock_oe_n_out(sclk_oe_n));
    sacr_host_model sacr_host_model_inst (.run_in(run), .nbits_in(4'hd), .data_in(dpin),
        .serial_bit_clock_out(hclk), .word_out(hword));
    task report_and_stop;
    begin
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task cmp(input [15:0] got, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // one conversion; bits taken at each internal bit clock rise
    task convert(input [11:0] c, input glitch);
        reg prev;
    begin
        prev = 1'b0;
        nb = 16'h0000;
        len = 16'h0000;
        @(posedge ref_clk_in);
        code <= c;
        // short low pulse after long high
        convert_start_n_n <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        convert_start_n_n <= 1'b1;
        while (len < 16'd2500 && busy_n === 1'b0)
        begin
            @(negedge ref_clk_in);
            len = len + 16'h0001;
            if (sclk === 1'b1 && prev === 1'b0)
            begin
                word = {word[10:0], dout};
                nb = nb + 16'h0001;
            end
            prev = sclk;
            if (glitch && len == 16'd300)
                @(posedge ref_clk_in) convert_start_n_n <= ~convert_start_n_n;
        end
        if (busy_n !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
        cmp({15'h0, len > BUSY_CYC - 20 && len < BUSY_CYC}, 16'h1);
        @(posedge ref_clk_in);
        convert_start_n_n <= 1'b1;
        // starts kept 25 us apart, convert high long before
        repeat (1000) @(posedge ref_clk_in);
    end
    endtask
    task t_internal;
        integer k;
    begin
        @(posedge ref_clk_in);
        src <= 1'b0;
        for (k = 0; k < 5; k = k + 1)
        begin
            convert(CODES[59-12*k -: 12], 1'b0);
            if (k > 0)
            begin
                cmp({4'h0, word}, {4'h0, CODES[71-12*k -: 12]});
                cmp(nb, 16'd12);
                cmp({15'h0, dout}, 16'h0);
            end
        end
    end
    endtask
    task t_ignore;
    begin
        @(posedge ref_clk_in);
        sel_n <= 1'b1;
        convert(12'h2c9, 1'b1);
        cmp({13'h0, sclk_oe_n, busy_oe_n, dout_oe_n}, 16'h7);
        sel_n <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        cmp({13'h0, sclk_oe_n, busy_oe_n, dout_oe_n}, 16'h0);
        convert(12'h000, 1'b0);
        cmp({4'h0, word}, 16'h02c9);
    end
    endtask
    task t_external;
    begin
        @(posedge ref_clk_in);
        src <= 1'b1;
        convert(12'h6b1, 1'b0);
        cmp({15'h0, sclk_oe_n}, 16'h1);
        run <= 1'b1;
        repeat (200) @(posedge ref_clk_in);
        run <= 1'b0;
        cmp({3'h0, hword}, {3'h0, 12'h6b1, 1'b0});
    end
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        t_internal;
        t_ignore;
        t_external;
        report_and_stop;
    end
endmodule // sacr_core_tb_top
